// ==== hw/prio_irq_core.v ====
// Purpose : eight-level priority interrupt core with acknowledge
//           sequencing in call style or single-vector style
// Assumes : ack strobe pulses are synchronous to CLK_IN, one or more
//           cycles high; software programs over apb
// Notes   : answer byte is valid from one clock after the strobe rises to one clock after it falls
//
// Notes on behaviour
// - high request input sets its latch bit
// - resolver drives interrupt line when request qualifies
// - call style first strobe drives call opcode
// - call style second strobe drives address low byte
// - call style third strobe drives address high byte
// - auto end clears in-service after third call or second vector strobe
// - vector first strobe sets in-service, clears latch
// - vector byte: level low, word two high
// - no auto end: in-service held until command
// - auto end at trailing edge of last strobe
// - auto end lets equal/lower levels interrupt
// - highest current priority wins among requests
// - rotation makes served level lowest, circular
// - op word two selects rotate on auto end
// - end command with rotate rotates priorities
// - after reset level zero highest, seven lowest
// - non-specific end clears highest in-service bit
// - specific end clears only named level
// - nested mode: only strictly higher interrupts
`include "prio_irq_defs.vh"
module prio_irq_core
(
   // clock and reset
   input  wire        CLK_IN,
   input  wire        RST_N_IN,
   // apb slave
   input  wire        PSEL_IN,
   input  wire        PENABLE_IN,
   input  wire        PWRITE_IN,
   input  wire [11:0] PADDR_IN,
   input  wire [31:0] PWDATA_IN,
   output wire [31:0] PRDATA_OUT,
   output wire        PREADY_OUT,
   output wire        PSLVERR_OUT,
   // interrupt link to host
   input  wire [7:0]  REQ_IN,
   input  wire        ACK_STROBE_IN,
   output wire        CPU_INT_OUT,
   output wire [7:0]  ACK_DATA_OUT,
   output wire        ACK_DATA_OE_N_OUT
);
   // -----------------------------------------------------------------------
   // state
   // -----------------------------------------------------------------------
   localparam S_IDLE = 2'h0;
   localparam S_ONE  = 2'h1;
   localparam S_TWO  = 2'h2;
   localparam S_THREE = 2'h3;

   reg  [7:0]  request_latch_bits;
   reg  [7:0]  in_service_bits;
   reg  [7:0]  init_word_one;
   reg  [7:0]  init_word_two;
   reg  [2:0]  config_bits;
   reg  [2:0]  lowest_level;
   reg  [1:0]  ack_count;
   reg  [2:0]  held_level;
   reg         strobe_prev;
   reg  [7:0]  ack_data;
   reg         ack_oe_n;
   reg  [31:0] rd_data;

   wire        vector_style = config_bits[`CFG_VECTOR_STYLE];
   wire        auto_eos     = config_bits[`CFG_AUTO_EOS];
   wire        rotate_auto  = config_bits[`CFG_ROTATE_AUTO];

   // -----------------------------------------------------------------------
   // priority helpers
   // -----------------------------------------------------------------------
   // rank 0 is highest; level just after lowest_level has rank 0
   function [2:0] rank_of;
      input [2:0] level;
      input [2:0] lowest;
      begin
         rank_of = level - lowest - 3'h1;
      end
   endfunction

   // one-hot mask of a level, for takes and for clears
   function [7:0] level_bit;
      input [2:0] level;
      begin
         level_bit = 8'h01 << level;
      end
   endfunction

   // pick the set bit with the best rank; found flag in bit 3
   function [3:0] pick_best;
      input [7:0] bits;
      input [2:0] lowest;
      integer     i;
      reg   [2:0] lvl;
      reg         found;
      begin
         found = 1'b0;
         lvl   = 3'h0;
         for (i = 7; i >= 0; i = i - 1)
         begin
            if (bits[(lowest + 3'h1 + i[2:0]) & 3'h7])
            begin
               found = 1'b1;
               lvl   = lowest + 3'h1 + i[2:0];
            end
         end
         pick_best = {found, lvl};
      end
   endfunction

   wire [3:0] best_req = pick_best(request_latch_bits, lowest_level);
   wire [3:0] best_isr = pick_best(in_service_bits, lowest_level);

   // a request qualifies only above the best level in service
   wire req_qualifies = best_req[3] &&
        (!best_isr[3] ||
         rank_of(best_req[2:0], lowest_level) <
         rank_of(best_isr[2:0], lowest_level));

   // combinational from registers so the host sees a new winner at once;
   // it drops as soon as the winner moves into service
   assign CPU_INT_OUT = req_qualifies;

   // -----------------------------------------------------------------------
   // apb decode; zero wait states, unmapped reads zero with error
   // -----------------------------------------------------------------------
   wire apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
   // only aligned words up to status decode; the rest answer with error
   wire mapped = (PADDR_IN <= `ADDR_STATUS) && (PADDR_IN[1:0] == 2'h0);
   wire wr_op2 = apb_wr && (PADDR_IN == `ADDR_OP_TWO);
   wire eos_cmd = wr_op2 && PWDATA_IN[`OP2_EOS];
   wire [2:0] eos_level = PWDATA_IN[`OP2_SPECIFIC] ? PWDATA_IN[2:0]
                                                   : best_isr[2:0];
   wire eos_valid = PWDATA_IN[`OP2_SPECIFIC] || best_isr[3];

   // every register answers at once, so the access phase never waits
   assign PREADY_OUT  = 1'b1;
   assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;
   assign PRDATA_OUT  = rd_data;

   // read mux, registered so data comes from flip-flops
   always @(posedge CLK_IN)
   begin
      if (!RST_N_IN)
         rd_data <= 32'h0;
      else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN)
      begin
         case (PADDR_IN)
            `ADDR_INIT_ONE:   rd_data <= {24'h0, init_word_one};
            `ADDR_INIT_TWO:   rd_data <= {24'h0, init_word_two};
            `ADDR_CONFIG:     rd_data <= {29'h0, config_bits};
            `ADDR_REQ_LATCH:  rd_data <= {24'h0, request_latch_bits};
            `ADDR_IN_SERVICE: rd_data <= {24'h0, in_service_bits};
            `ADDR_STATUS:     rd_data <= {25'h0, lowest_level,
                                          ack_count, CPU_INT_OUT,
                                          vector_style};
            default:          rd_data <= 32'h0;
         endcase
      end
   end

   // -----------------------------------------------------------------------
   // acknowledge sequencing
   // -----------------------------------------------------------------------
   // the strobe is taken as synchronous; a pulse shorter than one clock
   // may be missed, a limit the host must respect
   wire strobe_rise = ACK_STROBE_IN && !strobe_prev;
   wire strobe_fall = !ACK_STROBE_IN && strobe_prev;
   wire last_count  = vector_style ? (ack_count == S_TWO)
                                   : (ack_count == S_THREE);
   wire seq_end     = strobe_fall && last_count;
   wire auto_clear  = seq_end && auto_eos;

   // software registers and rotation pointer
   always @(posedge CLK_IN)
   begin
      if (!RST_N_IN)
      begin
         init_word_one <= `RST_INIT_ONE;
         init_word_two <= `RST_INIT_TWO;
         config_bits   <= `RST_CONFIG;
         lowest_level  <= `RST_LOWEST;
      end
      else
      begin
         if (apb_wr && PADDR_IN == `ADDR_INIT_ONE)
            init_word_one <= PWDATA_IN[7:0];
         if (apb_wr && PADDR_IN == `ADDR_INIT_TWO)
            init_word_two <= PWDATA_IN[7:0];
         if (apb_wr && PADDR_IN == `ADDR_CONFIG)
            config_bits <= PWDATA_IN[2:0];
         else if (wr_op2 && PWDATA_IN[`OP2_SET_RAUTO])
            config_bits[`CFG_ROTATE_AUTO] <= PWDATA_IN[`OP2_RAUTO_VAL];
         // auto rotation takes the level just retired as the new lowest
         if (auto_clear && rotate_auto)
            lowest_level <= held_level;
         else if (eos_cmd && PWDATA_IN[`OP2_ROTATE] && eos_valid)
            lowest_level <= eos_level;
      end
   end

   // first strobe of a sequence takes the winner into service
   wire       ack_take    = strobe_rise && (ack_count == S_IDLE) &&
                            best_req[3];
   // auto end beats a software end command landing in the same cycle;
   // without auto end only a command retires a level
   wire       clear_hit   = auto_clear || (eos_cmd && eos_valid);
   wire [2:0] clear_level = auto_clear ? held_level
                                       : eos_level;
   wire [7:0] take_bits   = ack_take ? level_bit(best_req[2:0]) : 8'h00;
   wire [7:0] drop_bits   = clear_hit ? level_bit(clear_level) : 8'h00;
   wire [7:0] next_latch;
   wire [7:0] next_service;

   // -----------------------------------------------------------------------
   // per-level request and in-service bits
   // -----------------------------------------------------------------------
   // every level has the same two bits of next-state logic
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : g_level
         // a level still high re-latches at once, so it is never lost
         // when its take and a new request fall in one cycle
         assign next_latch[g]   = REQ_IN[g] |
                                  (request_latch_bits[g] & ~take_bits[g]);
         // a take beats a drop of the same bit: the set wins
         assign next_service[g] = take_bits[g] |
                                  (in_service_bits[g] & ~drop_bits[g]);
      end
   endgenerate

   // strobe counter, held level and the two bit vectors
   always @(posedge CLK_IN)
   begin
      if (!RST_N_IN)
      begin
         request_latch_bits <= 8'h00;
         in_service_bits    <= 8'h00;
         ack_count          <= S_IDLE;
         held_level         <= 3'h0;
         strobe_prev        <= 1'b0;
      end
      else
      begin
         strobe_prev        <= ACK_STROBE_IN;
         request_latch_bits <= next_latch;
         // auto clear frees the level being served, which lets equal and
         // lower levels in again before the routine ends
         in_service_bits    <= next_service;
         if (ack_take)
            held_level <= best_req[2:0];
         // the sequence ends on the fall of its last strobe
         if (seq_end)
            ack_count <= S_IDLE;
         else if (strobe_rise)
            ack_count <= ack_count + 2'h1;
      end
   end

   // -----------------------------------------------------------------------
   // answer byte; driven in the counted slot from one clock after strobe rise to one clock after its fall
   // -----------------------------------------------------------------------
   always @(posedge CLK_IN)
   begin
      if (!RST_N_IN)
      begin
         ack_data <= 8'h00;
         ack_oe_n <= 1'b1;
      end
      else if (strobe_rise)
      begin
         ack_oe_n <= 1'b0;
         // the first vector slot drives a zero byte the host ignores
         if (vector_style)
            ack_data <= (ack_count == S_ONE)
                        ? {init_word_two[7:3], held_level}
                        : 8'h00;
         else
         begin
            case (ack_count)
               S_IDLE:  ack_data <= `CALL_OPCODE;
               S_ONE:   ack_data <= init_word_one;
               S_TWO:   ack_data <= init_word_two;
               default: ack_data <= 8'h00;
            endcase
         end
      end
      else if (!ACK_STROBE_IN)
         ack_oe_n <= 1'b1;
   end

   // byte and enable both come from flip-flops, so the pins never glitch
   assign ACK_DATA_OUT      = ack_data;
   assign ACK_DATA_OE_N_OUT = ack_oe_n;

endmodule // prio_irq_core

// ==== hw/prio_irq_defs.vh ====
// Purpose : constants for the priority interrupt acknowledge core
// Assumes : plain Verilog-2005, included by bare name
// Notes   : byte addresses of the apb register words
`ifndef PRIO_IRQ_DEFS_VH
`define PRIO_IRQ_DEFS_VH
// -----------------------------------------------------------------------
// register byte addresses
// -----------------------------------------------------------------------
`define ADDR_INIT_ONE    12'h000
`define ADDR_INIT_TWO    12'h004
`define ADDR_CONFIG      12'h008
`define ADDR_OP_TWO      12'h00c
`define ADDR_REQ_LATCH   12'h010
`define ADDR_IN_SERVICE  12'h014
`define ADDR_STATUS      12'h018
// -----------------------------------------------------------------------
// config field positions
// -----------------------------------------------------------------------
`define CFG_VECTOR_STYLE 0
`define CFG_AUTO_EOS     1
`define CFG_ROTATE_AUTO  2
// -----------------------------------------------------------------------
// operation word two fields: [2:0] level, [3] specific, [4] rotate,
// [5] end of service, [6] set rotate-on-auto, [7] value for that setting
// -----------------------------------------------------------------------
`define OP2_SPECIFIC     3
`define OP2_ROTATE       4
`define OP2_EOS          5
`define OP2_SET_RAUTO    6
`define OP2_RAUTO_VAL    7
// -----------------------------------------------------------------------
// reset values and the call opcode
// -----------------------------------------------------------------------
`define RST_INIT_ONE     8'h00
`define RST_INIT_TWO     8'h00
`define RST_CONFIG       3'h0
`define RST_LOWEST       3'h7
`define CALL_OPCODE      8'hcd
`endif

// ==== tb/prio_irq_assertions.sv ====
// Purpose : port checks on the priority interrupt core
// Assumes : bound to every core instance
// Notes   : shadows config and init words from apb writes
`include "prio_irq_defs.vh"
module prio_irq_checker
(
   // clock and reset
   input wire        CLK_IN,
   input wire        RST_N_IN,
   // apb
   input wire        PSEL_IN,
   input wire        PENABLE_IN,
   input wire        PWRITE_IN,
   input wire [11:0] PADDR_IN,
   input wire [31:0] PWDATA_IN,
   input wire        PSLVERR_OUT,
   // ack link
   input wire        ACK_STROBE_IN,
   input wire [7:0]  ACK_DATA_OUT,
   input wire        ACK_DATA_OE_N_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] one;
   logic [7:0] two;
   logic       vec;
   logic [1:0] cnt;
   wire        s  = ACK_STROBE_IN;
   wire [7:0]  d  = ACK_DATA_OUT;
   wire        wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_N_IN);
   // slot counter wraps after the last strobe of the style in force
   always_ff @(posedge CLK_IN)
   begin
      if (!RST_N_IN)
      begin
         one <= 8'h00;
         two <= 8'h00;
         vec <= 1'b0;
         cnt <= 2'h0;
      end
      else
      begin
         if (wr && PADDR_IN == `ADDR_INIT_ONE) one <= PWDATA_IN[7:0];
         if (wr && PADDR_IN == `ADDR_INIT_TWO) two <= PWDATA_IN[7:0];
         if (wr && PADDR_IN == `ADDR_CONFIG) vec <= PWDATA_IN[0];
         if ($rose(s)) cnt <= (cnt == {~vec, vec}) ? 2'h0 : cnt + 2'h1;
      end
   end
   property p_oe_on; $rose(s) |=> !ACK_DATA_OE_N_OUT; endproperty
   a_oe_on: assert property (p_oe_on) else $error("no answer");
   property p_oe_off; !s |=> ACK_DATA_OE_N_OUT; endproperty
   a_oe_off: assert property (p_oe_off) else $error("bus not freed");
   property p_call_op;
      $rose(s) && !vec && cnt == 2'h0 |=> d == `CALL_OPCODE;
   endproperty
   a_call_op: assert property (p_call_op) else $error("bad opcode");
   property p_call_lo;
      $rose(s) && !vec && cnt == 2'h1 |=> d == one;
   endproperty
   a_call_lo: assert property (p_call_lo) else $error("bad low");
   property p_call_hi;
      $rose(s) && !vec && cnt == 2'h2 |=> d == two;
   endproperty
   a_call_hi: assert property (p_call_hi) else $error("bad high");
   property p_vec_one;
      $rose(s) && vec && cnt == 2'h0 |=> d == 8'h00;
   endproperty
   a_vec_one: assert property (p_vec_one) else $error("bad first");
   property p_vec_hi;
      $rose(s) && vec && cnt == 2'h1 |=> d[7:3] == two[7:3];
   endproperty
   a_vec_hi: assert property (p_vec_hi) else $error("bad vector");
   // error exactly in the access phase of an unmapped or unaligned word
   property p_err;
      PSLVERR_OUT == (PSEL_IN && PENABLE_IN &&
                      (PADDR_IN > `ADDR_STATUS || PADDR_IN[1:0] != 2'h0));
   endproperty
   a_err: assert property (p_err) else $error("stray error");
endmodule // prio_irq_checker
bind prio_irq_core prio_irq_checker prio_irq_checker_inst
(
   .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN),
   .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
   .PWDATA_IN(PWDATA_IN), .PSLVERR_OUT(PSLVERR_OUT),
   .ACK_STROBE_IN(ACK_STROBE_IN), .ACK_DATA_OUT(ACK_DATA_OUT),
   .ACK_DATA_OE_N_OUT(ACK_DATA_OE_N_OUT)
);

// ==== tb/host_ack_model.sv ====
// Purpose : host side issuing acknowledge strobes
// Assumes : task is called just after a rising edge
// Notes   : got holds {oe_n, byte} per slot
module host_ack_model
(
   input  wire        clk_in,
   input  wire [7:0]  data_in,
   input  wire        oe_n_in,
   output logic       strobe_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] got [0:2];
   initial strobe_out = 1'b0;
   // n pulses, each high for h edges; byte taken mid-cycle after lowering
   task automatic ack_seq(input int n, input int h);
      for (int i = 0; i < n; i++)
      begin
         strobe_out <= 1'b1;
         repeat (h) @(posedge clk_in);
         strobe_out <= 1'b0;
         // the byte stands until the fall is seen, so sample it settled
         @(negedge clk_in);
         got[i] = {oe_n_in, data_in};
         @(posedge clk_in);
         @(posedge clk_in);
      end
   endtask
endmodule // host_ack_model

// ==== tb/tb_top.sv ====
// Purpose : directed tests of the priority interrupt core
// Assumes : zero wait apb, host model for strobes
// Notes   : expected bytes built from written init words
`include "prio_irq_defs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rst_n, psel, penable, pwrite, pready, pslverr;
   logic        cpu_int, oe_n, strobe, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0]  req, ack_data;
   int          error_cnt, checks, cyc;
   always #10 clk = ~clk;
   prio_irq_core prio_irq_core_inst (.CLK_IN(clk), .RST_N_IN(rst_n),
      .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
      .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .REQ_IN(req),
      .ACK_STROBE_IN(strobe), .CPU_INT_OUT(cpu_int),
      .ACK_DATA_OUT(ack_data), .ACK_DATA_OE_N_OUT(oe_n));
   host_ack_model host_ack_model_inst (.clk_in(clk), .data_in(ack_data),
      .oe_n_in(oe_n), .strobe_out(strobe));
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checks++;
      if (g !== x)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h want %h", $time, g, x);
      end
   endtask
   // one apb transfer; held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] dat);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so a following setup never rewrites psel at once
      @(posedge clk);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] m, x);
      apb(1'b0, a, 32'h0);
      chk(q & m, x);
   endtask
   task automatic ack(input int n, input int h, input logic [23:0] x);
      host_ack_model_inst.ack_seq(n, h);
      for (int i = 0; i < n; i++)
         chk({23'h0, host_ack_model_inst.got[i]}, {24'h0, x[23-8*i -: 8]});
   endtask
   task automatic pulse(input logic [7:0] r);
      req <= r;
      @(posedge clk);
      req <= 8'h00;
      repeat (2) @(posedge clk);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         final_report();
      end
   end
   initial
   begin
      {rst_n, psel, penable, pwrite, req, paddr, pwdata} <= '0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk(cpu_int, 0);
      rc(`ADDR_STATUS, 32'hff, 32'h70);
      apb(1'b1, `ADDR_INIT_ONE, 32'h5a);
      apb(1'b1, `ADDR_INIT_TWO, 32'h3c);
      pulse(8'h88);
      rc(`ADDR_REQ_LATCH, 32'hff, 32'h88);
      chk(cpu_int, 1);
      ack(3, 1, 24'hcd5a3c);
      rc(`ADDR_IN_SERVICE, 32'hff, 32'h08);
      rc(`ADDR_REQ_LATCH, 32'hff, 32'h80);
      chk(cpu_int, 0);
      $display("test call style done");
      apb(1'b1, `ADDR_OP_TWO, 32'h30);
      rc(`ADDR_IN_SERVICE, 32'hff, 32'h00);
      rc(`ADDR_STATUS, 32'h70, 32'h30);
      apb(1'b1, `ADDR_CONFIG, 32'h1);
      ack(2, 3, 24'h003f00);
      apb(1'b1, `ADDR_OP_TWO, 32'h2f);
      rc(`ADDR_IN_SERVICE, 32'hff, 32'h00);
      pulse(8'h24);
      ack(2, 1, 24'h003d00);
      chk(cpu_int, 0);
      apb(1'b1, `ADDR_OP_TWO, 32'h20);
      $display("test vector and rotation done");
      apb(1'b1, `ADDR_CONFIG, 32'h3);
      apb(1'b1, `ADDR_OP_TWO, 32'hc0);
      ack(2, 1, 24'h003a00);
      rc(`ADDR_IN_SERVICE, 32'hff, 32'h00);
      rc(`ADDR_STATUS, 32'h70, 32'h20);
      pulse(8'h04);
      chk(cpu_int, 1);
      apb(1'b1, `ADDR_CONFIG, 32'h6);
      ack(3, 1, 24'hcd5a3c);
      rc(`ADDR_IN_SERVICE, 32'hff, 32'h00);
      rc(`ADDR_REQ_LATCH, 32'hff, 32'h00);
      chk(cpu_int, 0);
      apb(1'b0, 12'h01c, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      $display("test auto end done");
      final_report();
   end
endmodule // tb_top
